// ==== hw/stpf_flush.sv ====
// Flush sequencer for the address lookup table and the static table
`timescale 1ns/100ps
`default_nettype none
module stpf_flush
  import stpf_pkg::*;
#(
  parameter int NPORTS = STPF_NPORTS
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Start and status
  input wire logic start,
  input wire logic [NPORTS-1:0] start_mask,
  output logic busy,
  // Table handshakes
  output logic [NPORTS-1:0] flush_mask,
  output logic lut_flush_req,
  input wire logic lut_flush_ack,
  output logic static_flush_req,
  input wire logic static_flush_ack
);

  stpf_flush_t fl_reg;
  stpf_flush_t fl_next;

  // Walk both tables in turn
  assign fl_next = (fl_reg == STPF_FL_IDLE && start) ? STPF_FL_LUT :
    (fl_reg == STPF_FL_LUT && lut_flush_ack) ? STPF_FL_STATIC :
    (fl_reg == STPF_FL_STATIC && static_flush_ack) ? STPF_FL_IDLE : fl_reg;

  // Sequencer and mask registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fl_reg <= STPF_FL_IDLE;
      flush_mask <= '0;
    end else begin
      fl_reg <= fl_next;
      if (fl_reg == STPF_FL_IDLE && start) begin
        flush_mask <= start_mask;
      end
    end
  end

  assign busy = (fl_reg != STPF_FL_IDLE);
  assign lut_flush_req = (fl_reg == STPF_FL_LUT);
  assign static_flush_req = (fl_reg == STPF_FL_STATIC);

  // ****************************************
  // Assertions
  // ****************************************
  property p_flush_seq;
    @(posedge pclk) disable iff (!presetn)
    (!busy && start) |=> lut_flush_req && (flush_mask == $past(start_mask));
  endproperty
  a_flush_seq: assert property (p_flush_seq) else $error("Flush did not start");

  c_flush_done: cover property (@(posedge pclk) disable iff (!presetn)
    static_flush_req && static_flush_ack);

endmodule : stpf_flush
`default_nettype wire

// ==== hw/stpf_pkg.sv ====
// Package with register map, reset values and state types of the spanning tree port filter
package stpf_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int STPF_NPORTS = 6;
  localparam int STPF_ADDR_W = 8;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] STPF_OFF_GLOBAL = 8'h00;
  localparam logic [7:0] STPF_OFF_TAIL = 8'h04;
  localparam logic [7:0] STPF_OFF_FLUSH = 8'h08;
  localparam logic [7:0] STPF_OFF_STATE = 8'h0C;
  localparam logic [7:0] STPF_OFF_PORT0 = 8'h10;

  // ****************************************
  // Field positions of a port control register
  // ****************************************
  localparam int STPF_BIT_TXEN = 0;
  localparam int STPF_BIT_RXEN = 1;
  localparam int STPF_BIT_LDIS = 2;
  localparam int STPF_SUB_LSB = 3;
  localparam int STPF_STATE_W = 3;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [4:0] STPF_PORT_CTRL_RST = 5'h03;
  localparam logic STPF_RSTP_RST = 1'b0;
  localparam logic [31:0] STPF_TAIL_RST = 32'h00000000;

  // ****************************************
  // Sub-state codes for the shared 0/0/1 bit setting
  // ****************************************
  localparam logic [1:0] STPF_SUB_DISABLE = 2'h0;
  localparam logic [1:0] STPF_SUB_BLOCKING = 2'h1;
  localparam logic [1:0] STPF_SUB_LISTENING = 2'h2;

  // Port states seen by the forwarding decision
  typedef enum logic [2:0] {
    STPF_ST_DISABLE,
    STPF_ST_BLOCKING,
    STPF_ST_LISTENING,
    STPF_ST_LEARNING,
    STPF_ST_FORWARDING,
    STPF_ST_DISCARDING
  } stpf_state_t;

  // Flush sequencer states
  typedef enum logic [1:0] {
    STPF_FL_IDLE,
    STPF_FL_LUT,
    STPF_FL_STATIC
  } stpf_flush_t;

endpackage : stpf_pkg

// ==== hw/stpf_port.sv ====
// Per-port spanning tree state register and permits
`timescale 1ns/100ps
`default_nettype none
module stpf_port
  import stpf_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control and permits
  stpf_port_if.port pif
);

  // ****************************************
  // State decode
  // ****************************************
  stpf_state_t req_state;
  stpf_state_t state_reg;
  wire bits_off = !pif.tx_en && !pif.rx_en;
  wire bits_discard = bits_off && pif.learn_dis;
  wire bits_learning = bits_off && !pif.learn_dis;
  wire bits_forward = pif.tx_en && pif.rx_en && !pif.learn_dis;
  wire stpf_state_t sub_state = (pif.sub == STPF_SUB_BLOCKING) ? STPF_ST_BLOCKING :
    (pif.sub == STPF_SUB_LISTENING) ? STPF_ST_LISTENING : STPF_ST_DISABLE;

  // Bits to state, odd settings fall back to disable
  assign req_state = bits_forward ? STPF_ST_FORWARDING :
    bits_learning ? STPF_ST_LEARNING :
    (bits_discard && pif.rstp) ? STPF_ST_DISCARDING :
    bits_discard ? sub_state : STPF_ST_DISABLE;

  // New state only between frames
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= STPF_ST_FORWARDING;
    end else if (!pif.busy) begin
      state_reg <= req_state;
    end
  end

  // ****************************************
  // Permits, host port always open
  // ****************************************
  wire fwd = (state_reg == STPF_ST_FORWARDING);
  wire host_path = (state_reg == STPF_ST_LISTENING) || (state_reg == STPF_ST_LEARNING);
  assign pif.state = state_reg;
  assign pif.rx_user = pif.is_host || fwd;
  assign pif.rx_to_host = pif.is_host || fwd || host_path ||
    (state_reg == STPF_ST_BLOCKING);
  assign pif.tx_user = pif.is_host || fwd;
  assign pif.tx_from_host = pif.is_host || fwd || host_path;
  assign pif.learn = !pif.is_host &&
    (fwd || (state_reg == STPF_ST_LEARNING));

  // ****************************************
  // Assertions
  // ****************************************
  property p_hold_busy;
    @(posedge pclk) disable iff (!presetn)
    pif.busy |=> (state_reg == $past(state_reg));
  endproperty
  a_hold_busy: assert property (p_hold_busy) else $error("State changed in a frame");

  property p_fwd_bits;
    @(posedge pclk) disable iff (!presetn)
    (!pif.busy && pif.tx_en && pif.rx_en && !pif.learn_dis) |=>
      (state_reg == STPF_ST_FORWARDING) && pif.learn == !pif.is_host;
  endproperty
  a_fwd_bits: assert property (p_fwd_bits) else $error("Forwarding decode wrong");

  property p_rstp_learn;
    @(posedge pclk) disable iff (!presetn)
    (!pif.busy && pif.rstp && !pif.tx_en && !pif.rx_en && !pif.learn_dis) |=>
      (state_reg == STPF_ST_LEARNING);
  endproperty
  a_rstp_learn: assert property (p_rstp_learn) else $error("Rapid learning decode wrong");

endmodule : stpf_port
`default_nettype wire

// ==== hw/stpf_port_if.sv ====
// Interface between the top and one per-port state module
`timescale 1ns/100ps
`default_nettype none
interface stpf_port_if;
  import stpf_pkg::*;
  logic tx_en;
  logic rx_en;
  logic learn_dis;
  logic [1:0] sub;
  logic rstp;
  logic busy;
  logic is_host;
  stpf_state_t state;
  logic rx_user;
  logic rx_to_host;
  logic tx_user;
  logic tx_from_host;
  logic learn;
  modport ctl (output tx_en, rx_en, learn_dis, sub, rstp, busy, is_host,
    input state, rx_user, rx_to_host, tx_user, tx_from_host, learn);
  modport port (input tx_en, rx_en, learn_dis, sub, rstp, busy, is_host,
    output state, rx_user, rx_to_host, tx_user, tx_from_host, learn);
endinterface : stpf_port_if
`default_nettype wire

// ==== hw/stpf_top.sv ====
// Spanning tree port state filter with APB registers
// Function
// - The lowest-numbered tail-tagged port is the host port; others follow state control.
// - Transmit, receive and learning-disable bits per port select the port state.
// - Disable (0/0/1): no ordinary frames in or out, no learning.
// - Blocking (0/0/1): only frames to the host leave this port, no learning.
// - Listening (0/0/1): host traffic passes both ways, no learning.
// - Learning (0/0/0): only host traffic passes, source addresses learned.
// - Forwarding (1/1/0): all frames pass both ways, addresses learned.
// - Frames hitting an overriding static entry always reach the host.
// - Rapid mode: discarding (0/0/1) forwards no user traffic, no learning.
// - Ports with learning disabled can have their table entries flushed quickly.
// - Rapid learning and forwarding match the classic states.
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
module stpf_top
  import stpf_pkg::*;
#(
  parameter int NPORTS = STPF_NPORTS,
  parameter int ADDR_W = STPF_ADDR_W
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Frame activity per port
  input wire logic [NPORTS-1:0] port_busy,
  // Forwarding request
  input wire logic req_valid,
  input wire logic [$clog2(NPORTS)-1:0] req_src,
  input wire logic [NPORTS-1:0] req_dst,
  input wire logic req_override,
  // Forwarding answer
  output logic fwd_valid,
  output logic [NPORTS-1:0] fwd_mask,
  output logic fwd_learn,
  // Table flush handshakes
  output logic [NPORTS-1:0] flush_mask,
  output logic lut_flush_req,
  input wire logic lut_flush_ack,
  output logic static_flush_req,
  input wire logic static_flush_ack
);

  localparam int SW = $clog2(NPORTS);

  // ****************************************
  // Registers
  // ****************************************
  logic [4:0] port_ctrl_reg [NPORTS];
  logic rstp_reg;
  logic [NPORTS-1:0] tail_reg;
  logic [31:0] prdata_reg;
  logic fwd_valid_reg;
  logic [NPORTS-1:0] fwd_mask_reg;
  logic fwd_learn_reg;

  // ****************************************
  // APB decode
  // ****************************************
  wire [5:0] word_idx = paddr[7:2];
  wire [5:0] port_idx = word_idx - 6'h04;
  wire sel_global = (paddr[7:0] == STPF_OFF_GLOBAL);
  wire sel_tail = (paddr[7:0] == STPF_OFF_TAIL);
  wire sel_flush = (paddr[7:0] == STPF_OFF_FLUSH);
  wire sel_state = (paddr[7:0] == STPF_OFF_STATE);
  wire sel_port = (paddr[7:0] >= STPF_OFF_PORT0) && (paddr[1:0] == 2'h0) &&
    (int'(port_idx) < NPORTS);
  wire sel_high = (ADDR_W > 8) && (paddr >> 8) != '0;
  wire mapped = !sel_high &&
    (sel_global || sel_tail || sel_flush || sel_state || sel_port);
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire wr = access && pwrite && mapped;

  // Zero wait states, unmapped access gets an error
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  // ****************************************
  // Host port and per-port modules
  // ****************************************
  wire [NPORTS-1:0] host_mask = tail_reg & (~tail_reg + {{(NPORTS-1){1'b0}}, 1'b1});
  wire [NPORTS-1:0] ldis_v;
  wire [NPORTS-1:0] rx_user_v;
  wire [NPORTS-1:0] rx_to_host_v;
  wire [NPORTS-1:0] tx_user_v;
  wire [NPORTS-1:0] tx_from_host_v;
  wire [NPORTS-1:0] learn_v;
  wire [NPORTS*STPF_STATE_W-1:0] state_v;

  stpf_port_if pif [NPORTS] ();

  genvar g;
  generate
    for (g = 0; g < NPORTS; g++) begin : g_port
      // Port control register write
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          port_ctrl_reg[g] <= STPF_PORT_CTRL_RST;
        end else if (wr && sel_port && port_idx[SW-1:0] == SW'(g)) begin
          port_ctrl_reg[g] <= pwdata[4:0];
        end
      end

      // Feed the port module, collect its permits
      assign pif[g].tx_en = port_ctrl_reg[g][STPF_BIT_TXEN];
      assign pif[g].rx_en = port_ctrl_reg[g][STPF_BIT_RXEN];
      assign pif[g].learn_dis = port_ctrl_reg[g][STPF_BIT_LDIS];
      assign pif[g].sub = port_ctrl_reg[g][STPF_SUB_LSB+:2];
      assign pif[g].rstp = rstp_reg;
      assign pif[g].busy = port_busy[g];
      assign pif[g].is_host = host_mask[g];
      assign ldis_v[g] = port_ctrl_reg[g][STPF_BIT_LDIS];
      assign rx_user_v[g] = pif[g].rx_user;
      assign rx_to_host_v[g] = pif[g].rx_to_host;
      assign tx_user_v[g] = pif[g].tx_user;
      assign tx_from_host_v[g] = pif[g].tx_from_host;
      assign learn_v[g] = pif[g].learn;
      assign state_v[g*STPF_STATE_W+:STPF_STATE_W] = pif[g].state;

      stpf_port u_port (
        .pclk(pclk),
        .presetn(presetn),
        .pif(pif[g])
      );
    end
  endgenerate

  // ****************************************
  // Global and tail tag registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rstp_reg <= STPF_RSTP_RST;
      tail_reg <= STPF_TAIL_RST[NPORTS-1:0];
    end else begin
      if (wr && sel_global) rstp_reg <= pwdata[0];
      if (wr && sel_tail) tail_reg <= pwdata[NPORTS-1:0];
    end
  end

  // ****************************************
  // Flush sequencer
  // ****************************************
  logic flush_busy;
  wire flush_start = wr && sel_flush && !flush_busy;
  wire [NPORTS-1:0] flush_req_mask = pwdata[NPORTS-1:0] & ldis_v;

  stpf_flush #(
    .NPORTS(NPORTS)
  ) u_flush (
    .pclk(pclk),
    .presetn(presetn),
    .start(flush_start),
    .start_mask(flush_req_mask),
    .busy(flush_busy),
    .flush_mask(flush_mask),
    .lut_flush_req(lut_flush_req),
    .lut_flush_ack(lut_flush_ack),
    .static_flush_req(static_flush_req),
    .static_flush_ack(static_flush_ack)
  );

  // ****************************************
  // Read data, captured in the setup cycle
  // ****************************************
  wire [31:0] rd_port = sel_port ? {27'h0, port_ctrl_reg[port_idx[SW-1:0]]} : 32'h0;
  wire [31:0] rd_word = sel_high ? 32'h0 :
    sel_global ? {31'h0, rstp_reg} :
    sel_tail ? 32'(tail_reg) :
    sel_flush ? {31'h0, flush_busy} :
    sel_state ? 32'(state_v) : rd_port;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0;
    end else if (setup && !pwrite) begin
      prdata_reg <= rd_word;
    end
  end
  assign prdata = prdata_reg;

  // ****************************************
  // Forwarding decision
  // ****************************************
  wire [NPORTS-1:0] src_bit = {{(NPORTS-1){1'b0}}, 1'b1} << req_src;
  wire src_host = |(host_mask & src_bit);
  wire src_rx_user = |(rx_user_v & src_bit);
  wire src_rx_host = |(rx_to_host_v & src_bit);
  wire src_learn = |(learn_v & src_bit);
  wire [NPORTS-1:0] dst_ok_user = src_rx_user ? tx_user_v : '0;
  wire [NPORTS-1:0] dst_ok_host = src_host ? tx_from_host_v : '0;
  wire [NPORTS-1:0] to_host_ok = (src_rx_user || src_rx_host) ? host_mask : '0;
  wire [NPORTS-1:0] allowed = (dst_ok_user | dst_ok_host | to_host_ok) & ~src_bit;
  wire [NPORTS-1:0] override_host = (req_override && !src_host) ? host_mask : '0;
  wire [NPORTS-1:0] fwd_next = (req_dst & allowed) | override_host;
  wire learn_next = req_valid && !src_host && src_learn;

  // Registered answer, one cycle after the request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_valid_reg <= 1'b0;
      fwd_mask_reg <= '0;
      fwd_learn_reg <= 1'b0;
    end else begin
      fwd_valid_reg <= req_valid;
      fwd_mask_reg <= req_valid ? fwd_next : '0;
      fwd_learn_reg <= learn_next;
    end
  end
  assign fwd_valid = fwd_valid_reg;
  assign fwd_mask = fwd_mask_reg;
  assign fwd_learn = fwd_learn_reg;

  // ****************************************
  // Assertions
  // ****************************************
  wire stpf_state_t src_state = stpf_state_t'(state_v[req_src*STPF_STATE_W+:STPF_STATE_W]);
  wire plain_req = req_valid && !src_host && !req_override;

  property p_disable;
    @(posedge pclk) disable iff (!presetn)
    (plain_req && src_state == STPF_ST_DISABLE) |=> fwd_mask == '0 && !fwd_learn;
  endproperty
  a_disable: assert property (p_disable) else $error("Disabled port passed a frame");

  property p_blocking;
    @(posedge pclk) disable iff (!presetn)
    (plain_req && src_state == STPF_ST_BLOCKING) |=>
      (fwd_mask & ~$past(host_mask)) == '0 && !fwd_learn;
  endproperty
  a_blocking: assert property (p_blocking) else $error("Blocking port passed user traffic");

  property p_listening;
    @(posedge pclk) disable iff (!presetn)
    (plain_req && src_state == STPF_ST_LISTENING && |(req_dst & host_mask)) |=>
      |(fwd_mask & $past(host_mask)) && !fwd_learn;
  endproperty
  a_listening: assert property (p_listening) else $error("Listening port misbehaved");

  property p_learning;
    @(posedge pclk) disable iff (!presetn)
    (plain_req && src_state == STPF_ST_LEARNING) |=>
      fwd_learn && (fwd_mask & ~$past(host_mask)) == '0;
  endproperty
  a_learning: assert property (p_learning) else $error("Learning port misbehaved");

  property p_forwarding;
    @(posedge pclk) disable iff (!presetn)
    (plain_req && src_state == STPF_ST_FORWARDING) |=>
      fwd_learn && fwd_mask == $past(req_dst & allowed);
  endproperty
  a_forwarding: assert property (p_forwarding) else $error("Forwarding port misbehaved");

  property p_override;
    @(posedge pclk) disable iff (!presetn)
    (req_valid && req_override && !src_host) |=>
      (fwd_mask & $past(host_mask)) == $past(host_mask);
  endproperty
  a_override: assert property (p_override) else $error("Override frame not at host");

  property p_discarding;
    @(posedge pclk) disable iff (!presetn)
    (plain_req && src_state == STPF_ST_DISCARDING) |=> fwd_mask == '0 && !fwd_learn;
  endproperty
  a_discarding: assert property (p_discarding) else $error("Discarding port passed a frame");

  property p_host_unique;
    @(posedge pclk) disable iff (!presetn)
    (|tail_reg) |-> $onehot(host_mask) && ((host_mask & tail_reg) == host_mask) &&
      (((host_mask - 1'b1) & tail_reg) == '0);
  endproperty
  a_host_unique: assert property (p_host_unique) else $error("Host port not unique");

  property p_flush_only_ldis;
    @(posedge pclk) disable iff (!presetn)
    flush_start |=> (flush_mask & ~$past(ldis_v)) == '0 ##1 flush_busy;
  endproperty
  a_flush_only_ldis: assert property (p_flush_only_ldis) else $error("Flushed a learning port");

  c_override: cover property (@(posedge pclk) disable iff (!presetn)
    req_valid && req_override && src_state == STPF_ST_DISABLE);
  c_blocking: cover property (@(posedge pclk) disable iff (!presetn)
    req_valid && src_state == STPF_ST_BLOCKING);
  c_learn: cover property (@(posedge pclk) disable iff (!presetn) fwd_learn);
  c_apb_err: cover property (@(posedge pclk) disable iff (!presetn) pslverr);

endmodule : stpf_top
`default_nettype wire

// ==== tb/spanning_tree_port_state_filter_bench.sv ====
// Self-checking bench for the spanning tree port filter
`timescale 1ns/100ps
`default_nettype none
module spanning_tree_port_state_filter_bench;
  import stpf_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [5:0] port_busy, req_dst, fwd_mask, flush_mask, host_dst;
  logic req_valid, req_override, fwd_valid, fwd_learn;
  logic [2:0] req_src;
  logic lut_req, lut_ack, st_req, st_ack;
  int error_cnt, checks;
  stpf_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_busy(port_busy), .req_valid(req_valid), .req_src(req_src),
    .req_dst(req_dst), .req_override(req_override), .fwd_valid(fwd_valid),
    .fwd_mask(fwd_mask), .fwd_learn(fwd_learn), .flush_mask(flush_mask),
    .lut_flush_req(lut_req), .lut_flush_ack(lut_ack), .static_flush_req(st_req),
    .static_flush_ack(st_ack));
  stpf_table_model #(.DELAY(3)) table_side (.pclk(pclk), .presetn(presetn),
    .lut_req(lut_req), .lut_ack(lut_ack), .st_req(st_req), .st_ack(st_ack));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One APB transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // One forwarding request, host sources aim only at the ports in host_dst
  task automatic fwd(input logic [2:0] s, input logic ov, input logic [5:0] m, input logic l);
    @(posedge pclk);
    req_valid <= 1'b1;
    req_src <= s;
    req_dst <= (s == 3'h0) ? host_dst : 6'h3F;
    req_override <= ov;
    @(posedge pclk);
    req_valid <= 1'b0;
    #1;
    chk("fwd_valid", 32'h1, {31'h0, fwd_valid});
    chk("fwd_mask", {26'h0, m}, {26'h0, fwd_mask});
    chk("fwd_learn", {31'h0, l}, {31'h0, fwd_learn});
  endtask : fwd
  // Reads the STATE word and compares it with six 3-bit codes
  task automatic state_chk(input logic [2:0] c [6]);
    logic [31:0] x;
    x = 32'h0;
    for (int i = 0; i < 6; i++) x[3*i +: 3] = c[i];
    apb(1'b0, STPF_OFF_STATE, 32'h0);
    chk("state", x, q);
  endtask : state_chk

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    apb(1'b0, STPF_OFF_PORT0, 32'h0);
    chk("port0 ctrl", 32'h3, q);
    state_chk('{3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4});
    apb(1'b0, 8'hFC, 32'h0);
    chk("pslverr", 32'h1, {31'h0, e});
  endtask : t_reset
  task automatic t_classic();
    logic [31:0] c [6];
    c = '{32'h3, 32'h04, 32'h0C, 32'h14, 32'h00, 32'h03};
    host_dst = 6'h38;
    apb(1'b1, STPF_OFF_TAIL, 32'h1);
    for (int i = 1; i < 6; i++) apb(1'b1, STPF_OFF_PORT0 + 8'(4 * i), c[i]);
    state_chk('{3'h4, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4});
    fwd(3'h0, 1'b0, 6'h38, 1'b0);
    fwd(3'h5, 1'b0, 6'h01, 1'b1);
    fwd(3'h1, 1'b0, 6'h00, 1'b0);
    fwd(3'h1, 1'b1, 6'h01, 1'b0);
    fwd(3'h2, 1'b0, 6'h01, 1'b0);
    fwd(3'h3, 1'b0, 6'h01, 1'b0);
    fwd(3'h4, 1'b0, 6'h01, 1'b1);
  endtask : t_classic
  task automatic t_rapid();
    host_dst = 6'h30;
    apb(1'b1, STPF_OFF_GLOBAL, 32'h1);
    state_chk('{3'h4, 3'h5, 3'h5, 3'h5, 3'h3, 3'h4});
    fwd(3'h3, 1'b0, 6'h00, 1'b0);
    fwd(3'h2, 1'b1, 6'h01, 1'b0);
    fwd(3'h4, 1'b0, 6'h01, 1'b1);
    fwd(3'h0, 1'b0, 6'h30, 1'b0);
    apb(1'b1, STPF_OFF_GLOBAL, 32'h0);
  endtask : t_rapid
  task automatic t_boundary();
    @(posedge pclk);
    port_busy <= 6'h20;
    apb(1'b1, STPF_OFF_PORT0 + 8'h14, 32'h04);
    fwd(3'h5, 1'b0, 6'h01, 1'b1);
    @(posedge pclk);
    port_busy <= 6'h00;
    fwd(3'h5, 1'b0, 6'h00, 1'b0);
    apb(1'b1, STPF_OFF_PORT0 + 8'h14, 32'h01);
    fwd(3'h5, 1'b0, 6'h00, 1'b0);
    apb(1'b1, STPF_OFF_PORT0 + 8'h14, 32'h1C);
    fwd(3'h5, 1'b0, 6'h00, 1'b0);
    apb(1'b1, STPF_OFF_PORT0 + 8'h14, 32'h03);
  endtask : t_boundary
  task automatic t_flush();
    int n;
    logic seen;
    seen = 1'b0;
    apb(1'b1, STPF_OFF_FLUSH, 32'h3F);
    #1;
    chk("lut_flush_req", 32'h1, {31'h0, lut_req});
    chk("flush_mask", 32'h0E, {26'h0, flush_mask});
    apb(1'b0, STPF_OFF_FLUSH, 32'h0);
    chk("flush busy", 32'h1, q);
    for (n = 0; n < 50 && (lut_req || st_req); n++) begin
      @(posedge pclk);
      #1;
      if (st_req === 1'b1) seen = 1'b1;
    end
    chk("static flush seen", 32'h1, {31'h0, seen});
    apb(1'b0, STPF_OFF_FLUSH, 32'h0);
    chk("flush idle", 32'h0, q);
  endtask : t_flush

  // ****************************************
  // Clock, sequence, watchdog and verdict
  // ****************************************
  task automatic summarize();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    {psel, penable, pwrite, req_valid, req_override} = 5'h00;
    {paddr, pwdata, port_busy, req_dst, req_src, host_dst} = '0;
    error_cnt = 0;
    checks = 0;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_classic();
    t_rapid();
    t_boundary();
    t_flush();
    summarize();
  end
  initial begin
    #(50 * 20000);
    error_cnt++;
    summarize();
  end
endmodule : spanning_tree_port_state_filter_bench
`default_nettype wire

// ==== tb/stpf_table_model.sv ====
// Table side model that acknowledges flush requests
`timescale 1ns/100ps
`default_nettype none
module stpf_table_model #(
  parameter int DELAY = 2
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Flush handshakes
  input wire logic lut_req,
  output logic lut_ack,
  input wire logic st_req,
  output logic st_ack
);
  int cnt;
  // Each request waits DELAY cycles, then gets one ack pulse, like a slow table
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      lut_ack <= 1'b0;
      st_ack <= 1'b0;
    end else begin
      lut_ack <= 1'b0;
      st_ack <= 1'b0;
      if ((lut_req && !lut_ack) || (st_req && !st_ack)) begin
        cnt <= (cnt == DELAY) ? 0 : cnt + 1;
        lut_ack <= lut_req && cnt == DELAY;
        st_ack <= st_req && !lut_req && cnt == DELAY;
      end
    end
  end
endmodule : stpf_table_model
`default_nettype wire
